// >>> rtl/addr_decode_pkg.sv
// shared constants and carriers of the system address decoder
// assumes one 50 MHz system bus clock and a 32-bit byte address
`default_nettype none

package addr_decode_pkg;

  // ************************************************************
  // address layout
  // ************************************************************
  localparam int          ADDR_W          = 32;      // bus address width
  localparam int          REGION_LSB      = 28;      // top nibble picks a 256 MB region
  localparam int          REGION_W        = 4;       // sixteen regions
  localparam int          NUM_CS          = 8;       // external chip selects
  localparam logic [3:0]  REGION_INT      = 4'h0;    // internal memories
  localparam logic [3:0]  REGION_CS_FIRST = 4'h1;    // drives chip select zero
  localparam logic [3:0]  REGION_CS_LAST  = 4'h8;    // drives chip select seven
  localparam logic [3:0]  REGION_PERIPH   = 4'hF;    // peripheral bus bridge

  // ************************************************************
  // second level decode inside region zero (1 MB blocks)
  // ************************************************************
  localparam int          BLK_LSB         = 20;      // 1 MB granularity
  localparam int          BLK_W           = 8;       // blocks in a 256 MB region
  localparam logic [7:0]  BLK_ALIAS       = 8'h00;   // remappable block at zero
  localparam logic [7:0]  BLK_ROM         = 8'h01;   // fixed rom base 0x10_0000
  localparam logic [7:0]  BLK_SRAM        = 8'h02;   // fixed sram base 0x20_0000
  localparam logic [7:0]  BLK_USBH        = 8'h03;   // usb host regs 0x30_0000
  localparam int          SRAM_BYTES      = 16384;   // internal sram size
  localparam int          ROM_BYTES       = 131072;  // internal rom size

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic        RST_REMAPPED    = 1'b0;    // no remap after reset
  localparam logic        RST_BOOT_ROM    = 1'b0;    // rom alias off until latched
  localparam logic [1:0]  RST_SYNC        = 2'h0;    // boot pin synchroniser

  // boot pin capture sequence after reset release
  typedef enum logic [1:0] {
    BOOT_WAIT  = 2'b00,  // first edge after release
    BOOT_FILL  = 2'b01,  // synchroniser filling
    BOOT_LATCH = 2'b10,  // take the synchronised level
    BOOT_DONE  = 2'b11   // level held until next reset
  } boot_state_e;

  // access request from a bus master
  typedef struct packed {
    logic              valid;  // request present this cycle
    logic [ADDR_W-1:0] addr;   // byte address
  } bus_req_s;

  // registered routing answer
  typedef struct packed {
    logic              valid;    // answer for one request
    logic [NUM_CS-1:0] ext_cs;   // one-hot external chip select
    logic              sram;     // internal sram selected
    logic              rom;      // internal rom selected
    logic              usbh;     // usb host registers selected
    logic              periph;   // peripheral bridge selected
    logic              abort;    // unmapped access
    logic [ADDR_W-1:0] addr;     // address passed to the target
  } route_s;

endpackage

`default_nettype wire

// >>> rtl/pin_sync.sv
// two flip-flop synchroniser for a level from a pin
// assumes the level changes slowly against the clock
`default_nettype none

module pin_sync
  import addr_decode_pkg::*;
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  // level
  input  wire logic pin_i,
  output logic      level_o
);

  // ************************************************************
  // synchroniser stages
  // ************************************************************
  logic [1:0] sync_q;  // [0] is only read by [1]

  // stage zero feeds stage one and nothing else
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_q <= RST_SYNC;
    end else if (ce_i) begin
      sync_q <= {sync_q[0], pin_i};
    end
  end

  assign level_o = sync_q[1];

endmodule

`default_nettype wire

// >>> rtl/addr_decoder.sv
// first level system bus address decoder with boot remap
// assumes requests and remap command come from logic on mclk_i,
// and the boot select level comes from a pin
`default_nettype none


module addr_decoder
  import addr_decode_pkg::*;
(
  // clock and reset
  input  wire logic     mclk_i,
  input  wire logic     resetn_i,
  input  wire logic     ce_i,
  // bus master side
  input  wire bus_req_s req_i,
  input  wire logic     remap_cmd_i,
  // boot strap pin
  input  wire logic     boot_select_pin_i,
  // target side
  output route_s        route_o,
  // status
  output logic          remapped_o,
  output logic          boot_rom_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    boot_state_e boot_st;   // capture sequence of the strap
    logic        boot_rom;  // latched boot select level
    logic        remapped;  // remap command seen
    route_s      route;     // registered answer
  } dec_state_s;

  dec_state_s state_q;  // all flops of this module
  dec_state_s state_d;  // next value
  logic       boot_lvl; // synchronised boot select

  // ************************************************************
  // boot pin synchroniser
  // ************************************************************
  pin_sync u_boot_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .pin_i    (boot_select_pin_i),
    .level_o  (boot_lvl)
  );

  // ************************************************************
  // decode
  // ************************************************************
  logic [REGION_W-1:0] region;  // top nibble
  logic [BLK_W-1:0]    blk;     // 1 MB block in region zero

  assign region = req_i.addr[REGION_LSB +: REGION_W];
  assign blk    = req_i.addr[BLK_LSB +: BLK_W];

  // next state: boot capture, remap flag, one routing answer
  always_comb begin
    state_d             = state_q;
    state_d.route       = '0;
    state_d.route.valid = req_i.valid;
    state_d.route.addr  = req_i.addr;

    // strap capture waits until the synchroniser holds the pin
    unique case (state_q.boot_st)
      BOOT_WAIT:  state_d.boot_st = BOOT_FILL;
      BOOT_FILL:  state_d.boot_st = BOOT_LATCH;
      BOOT_LATCH: begin
        state_d.boot_st  = BOOT_DONE;
        state_d.boot_rom = boot_lvl;
      end
      BOOT_DONE:  state_d.boot_st = BOOT_DONE;
    endcase

    // sticky until reset; a second command changes nothing
    if (remap_cmd_i) begin
      state_d.remapped = 1'b1;
    end

    if (req_i.valid) begin
      if (region == REGION_INT) begin
        // second level decode of the internal area
        unique case (blk)
          BLK_ALIAS: begin
            // map uses the state before this cycle's remap command
            if (state_q.remapped) begin
              state_d.route.sram = 1'b1;
            end else if (state_q.boot_rom) begin
              state_d.route.rom = 1'b1;
            end else begin
              state_d.route.abort = 1'b1;
            end
          end
          BLK_ROM:  state_d.route.rom  = 1'b1;
          BLK_SRAM: state_d.route.sram = 1'b1;
          BLK_USBH: state_d.route.usbh = 1'b1;
          default:  state_d.route.abort = 1'b1; // empty internal block
        endcase
      end else if (region >= REGION_CS_FIRST && region <= REGION_CS_LAST) begin
        // region n drives chip select n-1
        state_d.route.ext_cs = NUM_CS'(1) << (region - REGION_CS_FIRST);
      end else if (region == REGION_PERIPH) begin
        state_d.route.periph = 1'b1;
      end else begin
        state_d.route.abort = 1'b1;
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // clock enable freezes everything, the answer included
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q.boot_st  <= BOOT_WAIT;
      state_q.boot_rom <= RST_BOOT_ROM;
      state_q.remapped <= RST_REMAPPED;
      state_q.route    <= '0;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  assign route_o    = state_q.route;
  assign remapped_o = state_q.remapped;
  assign boot_rom_o = state_q.boot_rom;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  // an accepted request in a given region
  sequence s_req_region(logic [3:0] r);
    ce_i && req_i.valid && req_i.addr[REGION_LSB +: REGION_W] == r;
  endsequence

  // an accepted request in a given internal block
  sequence s_req_blk(logic [7:0] b);
    s_req_region(REGION_INT) ##0 req_i.addr[BLK_LSB +: BLK_W] == b;
  endsequence

  logic [4:0] sel_cnt;  // number of targets in the answer
  assign sel_cnt = 5'($countones(route_o.ext_cs)) + 5'(route_o.sram) + 5'(route_o.rom)
                 + 5'(route_o.usbh) + 5'(route_o.periph) + 5'(route_o.abort);

  AST_ONE_TARGET: assert property (
    route_o.valid |-> sel_cnt == 5'h1)
    else $error("answer must name exactly one target");

  // address taken from the accepted request, not from the cycle before:
  // while the enable is low the held answer belongs to an older request
  AST_ADDR_PASS: assert property (
    ce_i && req_i.valid |=> route_o.valid && route_o.addr == $past(req_i.addr))
    else $error("answer address differs from the accepted request");

  AST_EXT_CS: assert property (
    s_req_region(REGION_CS_FIRST + 4'h2) |=>
      route_o.ext_cs == 8'h04 && !route_o.abort)
    else $error("region three must drive chip select two");

  AST_CS_RANGE: assert property (
    ce_i && req_i.valid && req_i.addr[31:28] >= REGION_CS_FIRST
      && req_i.addr[31:28] <= REGION_CS_LAST |=> route_o.ext_cs != '0)
    else $error("external region without chip select");

  AST_INT_ONLY: assert property (
    route_o.valid && (route_o.sram || route_o.rom || route_o.usbh)
      |-> route_o.addr[31:28] == REGION_INT)
    else $error("internal memory selected outside region zero");

  AST_PERIPH: assert property (
    s_req_region(REGION_PERIPH) |=> route_o.periph && route_o.valid)
    else $error("region fifteen must reach the peripheral bridge");

  AST_ABORT_UNUSED: assert property (
    ce_i && req_i.valid && req_i.addr[31:28] > REGION_CS_LAST
      && req_i.addr[31:28] < REGION_PERIPH |=> route_o.abort)
    else $error("unused region did not abort");

  AST_SRAM_FIXED: assert property (
    s_req_blk(BLK_SRAM) |=> route_o.sram)
    else $error("sram not decoded at its fixed base");

  AST_SRAM_NOT_ZERO: assert property (
    s_req_blk(BLK_ALIAS) ##0 !remapped_o |=> !route_o.sram)
    else $error("sram visible at zero before remap");

  AST_SRAM_ALIAS: assert property (
    s_req_blk(BLK_ALIAS) ##0 remapped_o |=> route_o.sram ##0 !route_o.rom)
    else $error("sram missing at zero after remap");

  AST_ROM_FIXED: assert property (
    s_req_blk(BLK_ROM) |=> route_o.rom)
    else $error("rom not decoded at its fixed base");

  AST_ROM_ALIAS: assert property (
    s_req_blk(BLK_ALIAS) ##0 !remapped_o |=> route_o.rom == $past(boot_rom_o))
    else $error("rom alias does not follow the boot level");

  AST_USBH: assert property (
    s_req_blk(BLK_USBH) |=> route_o.usbh)
    else $error("usb host registers not decoded");

  AST_REMAP_STICKY: assert property (
    ce_i && remap_cmd_i |=> remapped_o [*8])
    else $error("remap flag did not set or did not hold");

  AST_BOOT_HOLD: assert property (
    $past(state_q.boot_st) == BOOT_DONE |-> $stable(boot_rom_o))
    else $error("boot level changed after capture");

endmodule

`default_nettype wire

// >>> bench/bus_master_model.sv
// bus master model: issues decoder requests and the remap command
// assumes callers enter its tasks just after a falling clock edge
`default_nettype none

module bus_master_model
  import addr_decode_pkg::*;
(
  // clock
  input  wire logic   mclk_i,
  // decoder answer
  input  wire route_s route_i,
  // requests
  output var bus_req_s req_o,
  output var logic     remap_cmd_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // bus cycles
  // ****************************************
  // quiet bus while reset is held
  initial begin
    req_o       = '0;
    remap_cmd_o = 1'b0;
  end

  // request stays up after the answer so calls run back to back
  task automatic access(input logic [ADDR_W-1:0] addr, output route_s seen);
    req_o.valid = 1'b1;
    req_o.addr  = addr;
    @(negedge mclk_i);
    seen = route_i;
  endtask

  // released address flips, so a stale value never looks valid;
  // one quiet edge follows, so the next call never re-raises at once
  task automatic idle();
    req_o.valid = 1'b0;
    req_o.addr  = ~req_o.addr;
    @(negedge mclk_i);
  endtask

  // one cycle command pulse
  task automatic remap();
    remap_cmd_o = 1'b1;
    @(negedge mclk_i);
    remap_cmd_o = 1'b0;
  endtask
endmodule

`default_nettype wire

// >>> bench/system_address_decoder_remap_tb.sv
// self-checking bench of the system address decoder
// assumes the decoder package, design and master model compile first
`default_nettype none

module system_address_decoder_remap_tb
  import addr_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic     mclk;         // system clock
  logic     resetn;       // reset, active low
  logic     ce;           // clock enable
  logic     boot_pin;     // boot strap level
  bus_req_s req;          // request from the master
  logic     remap_cmd;    // remap pulse
  route_s   route;        // routing answer
  logic     remapped;     // remap flag
  logic     boot_rom;     // latched boot level
  int       miscompares;  // mismatches seen
  int       check_count;  // comparisons made

  // ****************************************
  // design and partner
  // ****************************************
  addr_decoder uut (
    .mclk_i            (mclk),
    .resetn_i          (resetn),
    .ce_i              (ce),
    .req_i             (req),
    .remap_cmd_i       (remap_cmd),
    .boot_select_pin_i (boot_pin),
    .route_o           (route),
    .remapped_o        (remapped),
    .boot_rom_o        (boot_rom)
  );

  bus_master_model master (
    .mclk_i      (mclk),
    .route_i     (route),
    .req_o       (req),
    .remap_cmd_o (remap_cmd)
  );

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // expected routing worked out from the address map
  function automatic route_s expect_route(logic [31:0] a, logic rm, logic br);
    route_s e;
    e = '0;
    e.valid = 1'b1;
    e.addr = a;
    if (a[31:28] == 4'h0) begin
      // zero block: sram after remap, else rom on high boot
      if (a[27:20] == 8'h01 || (a[27:20] == 8'h00 && !rm && br)) e.rom = 1'b1;
      else if (a[27:20] == 8'h02 || (a[27:20] == 8'h00 && rm)) e.sram = 1'b1;
      else if (a[27:20] == 8'h03) e.usbh = 1'b1;
      else e.abort = 1'b1;
    end else if (a[31:28] <= 4'h8) e.ext_cs = 8'h01 << (a[31:28] - 4'h1);
    else if (a[31:28] == 4'hF) e.periph = 1'b1;
    else e.abort = 1'b1;
    return e;
  endfunction

  task automatic cmp_route(input logic [31:0] a, input logic rm, input logic br);
    route_s r;
    master.access(a, r);
    check("route", 64'(r), 64'(expect_route(a, rm, br)));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // reset, then a request on the very first edge, before boot latch
  task automatic do_reset(input logic boot);
    resetn = 1'b0;
    boot_pin = boot;
    master.idle();
    // idle edge plus four, six cycles with the opening edge
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    cmp_route(32'h0000_0010, 1'b0, 1'b0);
    master.idle();
    @(negedge mclk);
    check("boot level", 64'(boot_rom), 64'(boot));
    check("remap flag", 64'(remapped), 64'h0);
  endtask

  // both ends of regions one to fifteen, back to back
  task automatic check_regions();
    for (int g = 1; g < 16; g++) begin
      cmp_route({4'(g), 28'h0000000}, 1'b0, 1'b1);
      cmp_route({4'(g), 28'hFFFFFFC}, 1'b0, 1'b1);
    end
    master.idle();
  endtask

  // internal blocks including the empty block just past usb host and the one at the top of region zero
  task automatic check_internal(input logic rm, input logic br);
    logic [31:0] tbl [8] = '{32'h0000_0010, 32'h0001_FFFC, 32'h0010_0000,
      32'h0011_FFFC, 32'h0020_3FFC, 32'h0030_0000, 32'h0040_0000, 32'h0FF0_0000};
    foreach (tbl[i]) cmp_route(tbl[i], rm, br);
    master.idle();
  endtask

  // low enable freezes the answer of the last request
  task automatic check_enable();
    route_s r;
    master.access(32'h5000_0000, r);
    ce = 1'b0;
    master.access(32'hF000_0000, r);
    check("held route", 64'(r), 64'(expect_route(32'h5000_0000, 1'b0, 1'b1)));
    ce = 1'b1;
    cmp_route(32'hF000_0000, 1'b0, 1'b1);
    master.idle();
  endtask

  // a request on the command edge still sees the old map
  task automatic check_remap();
    route_s r;
    fork
      master.remap();
      master.access(32'h0000_0040, r);
    join
    check("same edge", 64'(r), 64'(expect_route(32'h0000_0040, 1'b0, 1'b1)));
    check("remap flag", 64'(remapped), 64'h1);
    master.idle();
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard, far beyond the roughly eighty cycles needed
  initial begin
    #50000;
    miscompares++;
    finish_test();
  end

  initial begin
    miscompares = 0;
    check_count = 0;
    resetn = 1'b0;
    ce = 1'b1;
    boot_pin = 1'b1;
    @(negedge mclk);
    do_reset(1'b1);
    check_internal(1'b0, 1'b1);
    check_regions();
    check_enable();
    check_remap();
    check_internal(1'b1, 1'b1);
    do_reset(1'b0);
    check_internal(1'b0, 1'b0);
    finish_test();
  end
endmodule

`default_nettype wire
